// ==== ocd_cfg.svh ====
// offsets, field positions and reset values of the oscillator config decode block
// Contract
// - bits 15-14 gate switching and fail-safe monitor
// - bit 12 picks secondary pins as crystal or port control
// - bit 10 low routes system clock out
// - bits 9-8 pick primary oscillator mode
// - bit 7 enables two-speed start-up
// - bit 6 enables secondary oscillator
// - bit 4 picks PLL reference at reset
// - bits 2-0 pick start-up oscillator
// - codes 011/110/111 reserved, use divided RC
// - security bit 31 low enforces code protection
// - key register bit 0 shows unlock status
`ifndef OCD_CFG_SVH
`define OCD_CFG_SVH
// ====================================================
// register byte offsets
`define OCD_OFF_CFG_CTRL 16'h3640
`define OCD_OFF_DEV_ID 16'h3660
`define OCD_OFF_UNLOCK_KEY 16'h3670
`define OCD_OFF_OSC_WORD 16'h3680
`define OCD_OFF_SEC_WORD 16'h3690
// ====================================================
// reset values and masks
`define OCD_RST_CFG_CTRL 32'h00000003
`define OCD_CFG_CTRL_WMASK 32'h0bff0008
`define OCD_CFG_CTRL_FIXED 32'h00000003
`define OCD_KEY_FIRST 32'haa996655
`define OCD_KEY_SECOND 32'h556699aa
`define OCD_ERASED_WORD 32'hffffffff
// ====================================================
// oscillator word field positions
`define OCD_MON_BIT 15
`define OCD_SWITCH_BIT 14
`define OCD_SEC_XTAL_BIT 12
`define OCD_PIN_IO_BIT 10
`define OCD_PRI_MODE_HI 9
`define OCD_PRI_MODE_LO 8
`define OCD_TWO_SPEED_BIT 7
`define OCD_SEC_EN_BIT 6
`define OCD_PLL_REF_BIT 4
`define OCD_START_HI 2
`define OCD_START_LO 0
// security word and key status positions
`define OCD_PROTECT_N_BIT 31
`define OCD_UNLOCK_STAT_BIT 0
`define OCD_CTRL_BOUNDARY_BIT 3
`endif

// ==== ocd_pkg.sv ====
// types shared by the oscillator config decode block
`default_nettype none
package ocd_pkg;
  // start-up source, one-hot
  typedef enum logic [4:0] {
    OCD_SRC_FAST_RC_DIV = 5'h01,
    OCD_SRC_PLL = 5'h02,
    OCD_SRC_PRIMARY = 5'h04,
    OCD_SRC_SECONDARY = 5'h08,
    OCD_SRC_LOW_POWER_RC = 5'h10
  } ocd_src_t;
  // primary oscillator mode, one-hot
  typedef enum logic [3:0] {
    OCD_PRI_EXT_CLOCK = 4'h1,
    OCD_PRI_STD_CRYSTAL = 4'h2,
    OCD_PRI_HIGH_SPEED = 4'h4,
    OCD_PRI_OFF = 4'h8
  } ocd_pri_mode_t;
  // unlock sequencer states, one-hot
  typedef enum logic [2:0] {
    OCD_LOCK_OPEN = 3'h1,
    OCD_LOCK_SHUT = 3'h2,
    OCD_LOCK_KEY1 = 3'h4
  } ocd_lock_t;
endpackage
`default_nettype wire

// ==== ocd_word_decode.sv ====
// combinational decode of the oscillator and security configuration words
`timescale 1ns/1ps
`default_nettype none
`include "ocd_cfg.svh"
module ocd_word_decode (
  // raw words
  input wire logic [31:0] osc_word,
  input wire logic [31:0] sec_word,
  // decoded fields
  output logic switch_en,
  output logic monitor_en,
  output logic sec_crystal,
  output logic sys_clk_out,
  output ocd_pkg::ocd_pri_mode_t pri_mode,
  output logic two_speed,
  output logic sec_osc_en,
  output logic pll_fast_rc,
  output ocd_pkg::ocd_src_t start_src,
  output logic start_reserved,
  output logic protect_on
);
  // ====================================================
  // single-bit fields
  assign switch_en = osc_word[`OCD_SWITCH_BIT];
  assign monitor_en = osc_word[`OCD_MON_BIT];
  assign sec_crystal = osc_word[`OCD_SEC_XTAL_BIT];
  assign sys_clk_out = ~osc_word[`OCD_PIN_IO_BIT];
  assign two_speed = osc_word[`OCD_TWO_SPEED_BIT];
  assign sec_osc_en = osc_word[`OCD_SEC_EN_BIT];
  assign pll_fast_rc = osc_word[`OCD_PLL_REF_BIT];
  assign protect_on = ~sec_word[`OCD_PROTECT_N_BIT];
  // reserved bits are ignored, whatever the programmer left in them
  // ====================================================
  // multi-bit fields
  always_comb begin
    unique case (osc_word[`OCD_PRI_MODE_HI:`OCD_PRI_MODE_LO])
      2'h3: pri_mode = ocd_pkg::OCD_PRI_OFF;
      2'h2: pri_mode = ocd_pkg::OCD_PRI_HIGH_SPEED;
      2'h1: pri_mode = ocd_pkg::OCD_PRI_STD_CRYSTAL;
      2'h0: pri_mode = ocd_pkg::OCD_PRI_EXT_CLOCK;
    endcase
  end
  // reserved codes fall back to the divided rc so the part always starts
  always_comb begin
    start_reserved = 1'b0;
    unique case (osc_word[`OCD_START_HI:`OCD_START_LO])
      3'h0: start_src = ocd_pkg::OCD_SRC_FAST_RC_DIV;
      3'h1: start_src = ocd_pkg::OCD_SRC_PLL;
      3'h2: start_src = ocd_pkg::OCD_SRC_PRIMARY;
      3'h4: start_src = ocd_pkg::OCD_SRC_SECONDARY;
      3'h5: start_src = ocd_pkg::OCD_SRC_LOW_POWER_RC;
      3'h3, 3'h6, 3'h7: begin
        start_src = ocd_pkg::OCD_SRC_FAST_RC_DIV;
        start_reserved = 1'b1;
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== ocd_top.sv ====
// oscillator configuration word decode with unlock key and apb registers
`timescale 1ns/1ps
`default_nettype none
`include "ocd_cfg.svh"
module ocd_top #(
  parameter int ADDR_W = 16,
  // arbitrary identity value, replace per variant
  parameter logic [31:0] DEV_ID_VALUE = 32'h1234_5678
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration memory loader
  input wire logic [31:0] nv_osc_word,
  input wire logic [31:0] nv_sec_word,
  input wire logic nv_valid,
  // clock source status, asynchronous
  input wire logic src_ready_async,
  // clock switch controls
  output logic cfg_loaded,
  output logic clock_switch_enable,
  output logic fail_safe_monitor_enable,
  output ocd_pkg::ocd_src_t startup_osc_select,
  output logic startup_code_reserved,
  output logic pll_ref_fast_rc,
  output logic two_speed_startup_enable,
  output logic run_on_fast_rc,
  // oscillator and pad controls
  output ocd_pkg::ocd_pri_mode_t primary_osc_mode,
  output logic secondary_osc_enable,
  output logic sec_pins_crystal,
  output logic sec_pins_port_ctrl,
  output logic clock_out_sysclk,
  output logic boundary_port_enable,
  // code protect and lock status
  output logic code_protect_active,
  output logic system_unlocked
);
  // ====================================================
  // state
  logic [31:0] osc_word; // captured oscillator word
  logic [31:0] sec_word; // captured security word
  logic [31:0] cfg_ctrl; // configuration control contents
  ocd_pkg::ocd_lock_t lock_state; // unlock sequencer
  ocd_pkg::ocd_lock_t next_lock;
  logic ready_meta; // synchroniser stage one
  logic ready_sync; // synchroniser stage two
  // ====================================================
  // decoded view of the incoming words
  logic d_switch, d_monitor, d_crystal, d_clk_out, d_two_speed;
  logic d_sec_en, d_pll, d_reserved, d_protect;
  ocd_pkg::ocd_pri_mode_t d_pri;
  ocd_pkg::ocd_src_t d_src;

  ocd_word_decode u_dec (
    .osc_word(nv_osc_word),
    .sec_word(nv_sec_word),
    .switch_en(d_switch),
    .monitor_en(d_monitor),
    .sec_crystal(d_crystal),
    .sys_clk_out(d_clk_out),
    .pri_mode(d_pri),
    .two_speed(d_two_speed),
    .sec_osc_en(d_sec_en),
    .pll_fast_rc(d_pll),
    .start_src(d_src),
    .start_reserved(d_reserved),
    .protect_on(d_protect)
  );

  // ====================================================
  // bus decode
  wire setup_ph = psel & ~penable;
  wire access_ph = psel & penable & pready;
  wire wr_fire = access_ph & pwrite;
  wire hit_ctrl = paddr == ADDR_W'(`OCD_OFF_CFG_CTRL);
  wire hit_id = paddr == ADDR_W'(`OCD_OFF_DEV_ID);
  wire hit_key = paddr == ADDR_W'(`OCD_OFF_UNLOCK_KEY);
  wire hit_osc = paddr == ADDR_W'(`OCD_OFF_OSC_WORD);
  wire hit_sec = paddr == ADDR_W'(`OCD_OFF_SEC_WORD);
  wire key_first = pwdata == `OCD_KEY_FIRST;
  wire key_second = pwdata == `OCD_KEY_SECOND;
  wire key_wr = wr_fire & hit_key;
  // control writes only land while unlocked
  wire ctrl_wr = wr_fire & hit_ctrl & system_unlocked;
  wire [31:0] key_view = {31'h0, system_unlocked};
  // unmapped addresses read zero and raise no error
  wire [31:0] next_rdata = hit_ctrl ? cfg_ctrl :
                           hit_id ? DEV_ID_VALUE :
                           hit_key ? key_view :
                           hit_osc ? osc_word :
                           hit_sec ? sec_word : 32'h0;
  wire [31:0] next_ctrl = (cfg_ctrl & ~`OCD_CFG_CTRL_WMASK) | (pwdata & `OCD_CFG_CTRL_WMASK)
                          | `OCD_CFG_CTRL_FIXED;
  // first loader strobe after reset is the only one honoured
  wire take = nv_valid & ~cfg_loaded;

  // ====================================================
  // unlock sequencer: any break in the key pair relocks
  always_comb begin
    next_lock = lock_state;
    if (key_wr) begin
      unique case (lock_state)
        ocd_pkg::OCD_LOCK_OPEN: begin
          next_lock = key_first ? ocd_pkg::OCD_LOCK_KEY1 : ocd_pkg::OCD_LOCK_SHUT;
        end
        ocd_pkg::OCD_LOCK_SHUT: begin
          next_lock = key_first ? ocd_pkg::OCD_LOCK_KEY1 : ocd_pkg::OCD_LOCK_SHUT;
        end
        ocd_pkg::OCD_LOCK_KEY1: begin
          if (key_second) begin
            next_lock = ocd_pkg::OCD_LOCK_OPEN;
          end else if (key_first) begin
            next_lock = ocd_pkg::OCD_LOCK_KEY1;
          end else begin
            next_lock = ocd_pkg::OCD_LOCK_SHUT;
          end
        end
        default: next_lock = ocd_pkg::OCD_LOCK_SHUT;
      endcase
    end else if (wr_fire && lock_state == ocd_pkg::OCD_LOCK_KEY1) begin
      // a write elsewhere between the two keys breaks the pair
      next_lock = ocd_pkg::OCD_LOCK_SHUT;
    end
  end

  // ====================================================
  // apb answer: zero wait states, data fetched in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= setup_ph ? next_rdata : prdata;
      pready <= setup_ph;
      pslverr <= 1'b0;
    end
  end

  // registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ctrl <= `OCD_RST_CFG_CTRL;
      lock_state <= ocd_pkg::OCD_LOCK_OPEN;
      system_unlocked <= 1'b1;
      boundary_port_enable <= 1'b0;
    end else begin
      cfg_ctrl <= ctrl_wr ? next_ctrl : cfg_ctrl;
      lock_state <= next_lock;
      system_unlocked <= next_lock == ocd_pkg::OCD_LOCK_OPEN;
      boundary_port_enable <= ctrl_wr ? pwdata[`OCD_CTRL_BOUNDARY_BIT]
                                      : cfg_ctrl[`OCD_CTRL_BOUNDARY_BIT];
    end
  end

  // ====================================================
  // word capture; outputs hold safe values until the loader speaks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_loaded <= 1'b0;
      osc_word <= `OCD_ERASED_WORD;
      sec_word <= `OCD_ERASED_WORD;
    end else if (take) begin
      cfg_loaded <= 1'b1;
      osc_word <= nv_osc_word;
      sec_word <= nv_sec_word;
    end
  end

  // decoded settings latched once, held until the next reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_switch_enable <= 1'b0;
      fail_safe_monitor_enable <= 1'b0;
      sec_pins_crystal <= 1'b0;
      sec_pins_port_ctrl <= 1'b1;
      clock_out_sysclk <= 1'b0;
      primary_osc_mode <= ocd_pkg::OCD_PRI_OFF;
      two_speed_startup_enable <= 1'b0;
      secondary_osc_enable <= 1'b0;
      pll_ref_fast_rc <= 1'b1;
      startup_osc_select <= ocd_pkg::OCD_SRC_FAST_RC_DIV;
      startup_code_reserved <= 1'b0;
      code_protect_active <= 1'b1;
    end else if (take) begin
      clock_switch_enable <= d_switch;
      fail_safe_monitor_enable <= d_monitor;
      sec_pins_crystal <= d_crystal;
      sec_pins_port_ctrl <= ~d_crystal;
      clock_out_sysclk <= d_clk_out;
      primary_osc_mode <= d_pri;
      two_speed_startup_enable <= d_two_speed;
      secondary_osc_enable <= d_sec_en;
      pll_ref_fast_rc <= d_pll;
      startup_osc_select <= d_src;
      startup_code_reserved <= d_reserved;
      code_protect_active <= d_protect;
    end
  end

  // ====================================================
  // two-speed start-up: stay on the fast rc until the source is ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_meta <= 1'b0;
      ready_sync <= 1'b0;
    end else begin
      ready_meta <= src_ready_async;
      ready_sync <= ready_meta;
    end
  end

  // once released it never re-enters, a late drop of ready is ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_on_fast_rc <= 1'b0;
    end else if (take) begin
      run_on_fast_rc <= d_two_speed;
    end else if (ready_sync) begin
      run_on_fast_rc <= 1'b0;
    end
  end

  // ====================================================
  // checks
  property p_switch;
    @(posedge pclk) disable iff (!presetn)
    take |=> (clock_switch_enable == $past(nv_osc_word[`OCD_SWITCH_BIT]))
             && (fail_safe_monitor_enable == $past(nv_osc_word[`OCD_MON_BIT]));
  endproperty
  a_switch: assert property (p_switch) else $error("switch or monitor mismatch");

  property p_sec_pins;
    @(posedge pclk) disable iff (!presetn)
    sec_pins_crystal != sec_pins_port_ctrl;
  endproperty
  a_sec_pins: assert property (p_sec_pins) else $error("secondary pins both or neither");

  property p_clk_out;
    @(posedge pclk) disable iff (!presetn)
    take |=> clock_out_sysclk == !$past(nv_osc_word[`OCD_PIN_IO_BIT]);
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("clock out routing wrong");

  property p_pri_mode;
    @(posedge pclk) disable iff (!presetn)
    (take && nv_osc_word[`OCD_PRI_MODE_HI:`OCD_PRI_MODE_LO] == 2'h2)
      |=> primary_osc_mode == ocd_pkg::OCD_PRI_HIGH_SPEED;
  endproperty
  a_pri_mode: assert property (p_pri_mode) else $error("primary mode wrong");

  property p_two_speed;
    @(posedge pclk) disable iff (!presetn)
    (take && !nv_osc_word[`OCD_TWO_SPEED_BIT]) |=> !run_on_fast_rc [*3];
  endproperty
  a_two_speed: assert property (p_two_speed) else $error("two-speed ran while off");

  property p_sec_en;
    @(posedge pclk) disable iff (!presetn)
    take |=> secondary_osc_enable == $past(nv_osc_word[`OCD_SEC_EN_BIT]);
  endproperty
  a_sec_en: assert property (p_sec_en) else $error("secondary enable wrong");

  property p_pll;
    @(posedge pclk) disable iff (!presetn)
    take |=> pll_ref_fast_rc == $past(nv_osc_word[`OCD_PLL_REF_BIT]);
  endproperty
  a_pll: assert property (p_pll) else $error("pll reference wrong");

  property p_start;
    @(posedge pclk) disable iff (!presetn)
    (take && nv_osc_word[`OCD_START_HI:`OCD_START_LO] == 3'h5)
      |=> startup_osc_select == ocd_pkg::OCD_SRC_LOW_POWER_RC;
  endproperty
  a_start: assert property (p_start) else $error("start-up source wrong");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
    (take && (nv_osc_word[`OCD_START_HI:`OCD_START_LO] >= 3'h6
              || nv_osc_word[`OCD_START_HI:`OCD_START_LO] == 3'h3))
      |=> startup_code_reserved && startup_osc_select == ocd_pkg::OCD_SRC_FAST_RC_DIV;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code not mapped");

  property p_protect;
    @(posedge pclk) disable iff (!presetn)
    take |=> code_protect_active == !$past(nv_sec_word[`OCD_PROTECT_N_BIT]);
  endproperty
  a_protect: assert property (p_protect) else $error("code protect wrong");

  // half a key pair must never open the lock
  property p_unlock;
    @(posedge pclk) disable iff (!presetn)
    (key_wr && key_first) |=> !system_unlocked;
  endproperty
  a_unlock: assert property (p_unlock) else $error("first key alone unlocked");

  property p_key_pair;
    @(posedge pclk) disable iff (!presetn)
    (key_wr && key_second && lock_state == ocd_pkg::OCD_LOCK_KEY1) |=> system_unlocked;
  endproperty
  a_key_pair: assert property (p_key_pair) else $error("key pair did not unlock");

  property p_relock;
    @(posedge pclk) disable iff (!presetn)
    (key_wr && !key_first && !key_second) |=> !system_unlocked ##1 !system_unlocked;
  endproperty
  a_relock: assert property (p_relock) else $error("bad key left unlocked");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    (cfg_loaded && $past(cfg_loaded)) |-> $stable(startup_osc_select) && $stable(code_protect_active)
      && $stable(primary_osc_mode) && $stable(clock_switch_enable);
  endproperty
  a_hold: assert property (p_hold) else $error("settings moved after load");

  property p_answer;
    @(posedge pclk) disable iff (!presetn)
    setup_ph |=> pready && !pslverr;
  endproperty
  a_answer: assert property (p_answer) else $error("apb answer late");
endmodule
`default_nettype wire

// ==== ocd_top_tb.sv ====
// self-checking testbench for the oscillator config decode top
`timescale 1ns/1ps
`default_nettype none
`include "ocd_cfg.svh"
// one compare: counts it, reports a mismatch at once
`define CHK(nm, ex, gt) begin \
  total_checks++; \
  if ((gt) !== (ex)) begin \
    fails++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, gt); \
  end \
end
module ocd_top_tb;
  // ====================================================
  // signals
  localparam logic [31:0] ID_VAL = 32'h5a5a_0001; // arbitrary identity value
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic nv_valid = 1'b0;
  logic src_ready_async = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] nv_osc_word = 32'h0;
  logic [31:0] nv_sec_word = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cfg_loaded, sw_en, mon_en, start_rsv, pll_rc, two_spd, run_rc;
  logic sec_en, pins_xtal, pins_port, clk_out, bnd_en, prot, unlocked;
  ocd_pkg::ocd_src_t start_sel;
  ocd_pkg::ocd_pri_mode_t pri_mode;
  int fails = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic err;
  // ====================================================
  // clock and design
  always #2.5 pclk = ~pclk;
  ocd_top #(.ADDR_W(16), .DEV_ID_VALUE(ID_VAL)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nv_osc_word(nv_osc_word), .nv_sec_word(nv_sec_word), .nv_valid(nv_valid),
    .src_ready_async(src_ready_async), .cfg_loaded(cfg_loaded), .clock_switch_enable(sw_en),
    .fail_safe_monitor_enable(mon_en), .startup_osc_select(start_sel),
    .startup_code_reserved(start_rsv), .pll_ref_fast_rc(pll_rc), .two_speed_startup_enable(two_spd),
    .run_on_fast_rc(run_rc), .primary_osc_mode(pri_mode), .secondary_osc_enable(sec_en),
    .sec_pins_crystal(pins_xtal), .sec_pins_port_ctrl(pins_port), .clock_out_sysclk(clk_out),
    .boundary_port_enable(bnd_en), .code_protect_active(prot), .system_unlocked(unlocked));
  // ====================================================
  // verdict, the only exit of the run
  task automatic tally_and_finish;
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ====================================================
  // bus and loader helpers
  // one apb transfer; request held until pready seen high at an edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // access phase: wait for the edge at which pready is seen high
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) begin
      fails++;
      tally_and_finish();
    end
    // data taken at that same edge, before the design updates anything
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // reset held three cycles; default outputs checked while it is held
  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    src_ready_async <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    `CHK("rst_port", 1'b1, pins_port)
    `CHK("rst_pri", 4'h8, pri_mode)
    `CHK("rst_src", 5'h01, start_sel)
    `CHK("rst_prot", 1'b1, prot)
    `CHK("rst_unl", 1'b1, unlocked)
    `CHK("rst_load", 1'b0, cfg_loaded)
    @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // present both words for one edge
  task automatic load(input logic [31:0] o, input logic [31:0] s);
    @(posedge pclk);
    nv_valid <= 1'b1;
    nv_osc_word <= o;
    nv_sec_word <= s;
    @(posedge pclk);
    nv_valid <= 1'b0;
    #1;
  endtask
  // expected one-hot start source; reserved codes fall back to divided rc
  function automatic logic [4:0] exp_src(input logic [2:0] c);
    case (c)
      3'h1: exp_src = 5'h02;
      3'h2: exp_src = 5'h04;
      3'h4: exp_src = 5'h08;
      3'h5: exp_src = 5'h10;
      default: exp_src = 5'h01;
    endcase
  endfunction
  // ====================================================
  // scenarios
  // register map reset values, read-only id, unmapped place
  task automatic t_reg_reset;
    do_reset();
    apb(1'b0, `OCD_OFF_CFG_CTRL, 32'h0);
    `CHK("ctrl_rst", 32'h0000_0003, rd)
    apb(1'b0, `OCD_OFF_UNLOCK_KEY, 32'h0);
    `CHK("key_rst", 32'h0000_0001, rd)
    apb(1'b1, `OCD_OFF_DEV_ID, 32'h0);
    apb(1'b0, `OCD_OFF_DEV_ID, 32'h0);
    `CHK("id_ro", ID_VAL, rd)
    apb(1'b0, `OCD_OFF_OSC_WORD, 32'h0);
    `CHK("osc_preload", 32'hffff_ffff, rd)
    apb(1'b0, 16'h3000, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("slverr", 1'b0, err)
  endtask
  // every start code, with the other fields walked alongside
  task automatic t_decode;
    logic [31:0] o;
    logic [31:0] s;
    int n;
    for (int i = 0; i < 8; i++) begin
      o = 32'hffff_2828; // reserved bits programmed as ones
      o[15:14] = i[1:0];
      o[12] = i[0];
      o[10] = i[1];
      o[9:8] = i[2:1];
      o[7] = i[2];
      o[6] = i[0];
      o[4] = ~i[1];
      o[2:0] = i[2:0];
      s = i[0] ? 32'hffff_ffff : 32'h7fff_ffff;
      do_reset();
      load(o, s);
      `CHK("loaded", 1'b1, cfg_loaded)
      `CHK("switch", o[14], sw_en)
      `CHK("monitor", o[15], mon_en)
      `CHK("xtal", o[12], pins_xtal)
      `CHK("port", ~o[12], pins_port)
      `CHK("clk_out", ~o[10], clk_out)
      `CHK("pri", 4'h1 << o[9:8], pri_mode)
      `CHK("two_spd", o[7], two_spd)
      `CHK("run_rc", o[7], run_rc)
      `CHK("sec_en", o[6], sec_en)
      `CHK("pll_rc", o[4], pll_rc)
      `CHK("src", exp_src(o[2:0]), start_sel)
      `CHK("rsv", (o[2:0] == 3'h3 || o[2:0] >= 3'h6), start_rsv)
      `CHK("prot", ~s[31], prot)
      // source becomes ready: two-speed phase ends within a few cycles
      @(posedge pclk);
      src_ready_async <= 1'b1;
      n = 0;
      while (run_rc !== 1'b0 && n < 10) begin
        @(posedge pclk);
        #1;
        n++;
      end
      `CHK("run_rc_end", 1'b0, run_rc)
    end
  endtask
  // a second load before reset must not disturb anything
  task automatic t_hold;
    do_reset();
    load(32'hffff_b9a9, 32'h7fff_ffff);
    load(32'hffff_6a6e, 32'hffff_ffff);
    repeat (2) @(posedge pclk);
    #1;
    `CHK("hold_mon", 1'b1, mon_en)
    `CHK("hold_src", 5'h02, start_sel)
    `CHK("hold_prot", 1'b1, prot)
    apb(1'b0, `OCD_OFF_OSC_WORD, 32'h0);
    `CHK("hold_word", 32'hffff_b9a9, rd)
  endtask
  // lock, refused control write, half key, full key, accepted write
  task automatic t_unlock;
    do_reset();
    apb(1'b1, `OCD_OFF_UNLOCK_KEY, 32'h0000_0000);
    // lock status is launched by the access edge, look once it has settled
    #1;
    `CHK("locked", 1'b0, unlocked)
    apb(1'b1, `OCD_OFF_CFG_CTRL, 32'h0000_0008);
    apb(1'b0, `OCD_OFF_CFG_CTRL, 32'h0);
    `CHK("ctrl_lock", 32'h0000_0003, rd)
    `CHK("bnd_lock", 1'b0, bnd_en)
    apb(1'b1, `OCD_OFF_UNLOCK_KEY, `OCD_KEY_FIRST);
    apb(1'b0, `OCD_OFF_UNLOCK_KEY, 32'h0);
    `CHK("half_key", 32'h0, rd)
    apb(1'b1, `OCD_OFF_UNLOCK_KEY, `OCD_KEY_FIRST);
    apb(1'b1, `OCD_OFF_UNLOCK_KEY, `OCD_KEY_SECOND);
    apb(1'b0, `OCD_OFF_UNLOCK_KEY, 32'h0);
    `CHK("key_open", 32'h1, rd)
    `CHK("unl", 1'b1, unlocked)
    apb(1'b1, `OCD_OFF_CFG_CTRL, 32'h0000_0008);
    apb(1'b0, `OCD_OFF_CFG_CTRL, 32'h0);
    `CHK("ctrl_open", 32'h0000_000b, rd)
    `CHK("bnd_open", 1'b1, bnd_en)
  endtask
  // ====================================================
  // main sequence and watchdog
  initial begin
    t_reg_reset();
    t_decode();
    t_hold();
    t_unlock();
    tally_and_finish();
  end
  // a hang counts as a mismatch; the run needs well under this span
  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
